/* File: sleep_ctrl_map.svh */
`ifndef SLEEP_CTRL_MAP_SVH
`define SLEEP_CTRL_MAP_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_GIRQ 12'h000
`define ADDR_SLEEP_CTRL 12'h004
`define ADDR_PERIPH_CTRL 12'h008
`define ADDR_STATUS 12'h00c

// ----------------------------------------
// general_irq_control fields
// ----------------------------------------
`define GIRQ_LINE_ONE 7
`define GIRQ_LINE_ZERO 6
`define GIRQ_LINE_TWO 5
`define GIRQ_VSEL 1
`define GIRQ_UNLOCK 0
`define GIRQ_RESET 8'h00
`define GIRQ_RW_MASK 8'he3

// ----------------------------------------
// sleep control fields
// ----------------------------------------
`define SLP_MODE_LSB 0
`define SLP_MODE_MSB 2
`define SLP_SLEEP_EN 3
`define SLP_RESET 8'h00
`define SLP_RW_MASK 8'h0f

// ----------------------------------------
// peripheral control fields
// ----------------------------------------
`define PER_ADC_EN 0
`define PER_CMP_DIS 1
`define PER_T2_ASYNC 2
`define PER_T2_OVF_IE 3
`define PER_T2_CMP_IE 4
`define PER_JTAG_EN 5
`define PER_RESET 8'h00
`define PER_RW_MASK 8'h3f

// ----------------------------------------
// timing
// ----------------------------------------
`define UNLOCK_CYCLES 3'h4
`define STARTUP_BASE 20'h00010
`define RST_MIN_NS 1500
`define CLK_PERIOD_NS 10
`define RST_MIN_CYCLES ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: sleep_ctrl_pkg.sv */
package sleep_ctrl_pkg;

	typedef enum logic [2:0]
	{
		mode_idle = 3'h0,
		mode_adc_noise = 3'h1,
		mode_power_down = 3'h2,
		mode_power_save = 3'h3
	} sleep_mode_t;

	typedef struct packed
	{
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic async_timer;
		logic oscillator;
	} clock_enables_t;

	typedef struct packed
	{
		logic ext_line_zero_level;
		logic ext_line_one_level;
		logic ext_line_two;
		logic ext_reset;
		logic watchdog_reset;
		logic brownout_reset;
		logic twi_addr_match;
		logic timer2_ovf;
		logic timer2_cmp;
		logic adc_done;
		logic storage_ready;
		logic comparator;
		logic other_periph;
	} wake_events_t;

endpackage : sleep_ctrl_pkg

/* File: sleep_ctrl.sv */
// Functional notes
// - mode 000 sleep enters idle; core and flash clocks stop, others run.
// - idle wakes on external and internal peripheral interrupts.
// - with converter enabled, entering idle or noise mode starts one conversion.
// - comparator disable powers comparator down, removing it as idle wake source.
// - mode 001 enters noise reduction; io, core, flash clocks stop.
// - noise mode keeps converter, ext irqs, two-wire watch, timer 2, watchdog.
// - noise mode wakes only on its listed event set.
// - mode 010 enters power-down; oscillator stopped, all generated clocks gated.
// - power-down keeps ext irq detect, two-wire watch and watchdog running.
// - power-down wakes only on resets, address match, level line 0/1, line 2.
// - power-down wake waits a start-up delay chosen by clock source fuses.
// - mode 011 enters power-save; timer 2 runs when async select set.
// - power-save timer 2 wake needs its enable and global enable.
// - power-save gates every clock except the async timer clock.
// - port pins float at once while reset is active, without a clock.
// - reset low longer than minimum pulse resets; shorter pulses may not.
// - with debug port enabled, its three pull-ups stay on during reset.
// - irq control holds line enables 7..5, vector bits 1..0, zeros elsewhere.
// - vector select picks program memory start or boot section start.
// - unlock then write select within four cycles; irqs blocked meanwhile.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sleep_ctrl_map.svh"

module sleep_ctrl
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_instr,
	input wire logic global_irq_enable,
	input wire logic [3:0] clock_source_fuses,
	input wire logic reset_pin_n,
	input wire sleep_ctrl_pkg::wake_events_t wake_in,
	output sleep_ctrl_pkg::clock_enables_t clk_en,
	output logic core_running,
	output logic adc_start,
	output logic comparator_power,
	output logic vector_base_select,
	output logic irq_block,
	output logic [2:0] ext_irq_enable,
	output logic pin_reset,
	output logic pins_float,
	output logic [2:0] jtag_pullup_en
);

	typedef enum logic [1:0]
	{
		st_run,
		st_sleep,
		st_startup
	} state_t;

	// ----------------------------------------
	// reset pin filter
	// ----------------------------------------
	logic rst_s1_reg, rst_s2_reg, rst_s3_reg;
	logic [7:0] rst_cnt_reg;
	logic pin_reset_reg;
	logic rst_low;
	logic rst_low_reg;

	always_ff @(posedge clock)
	begin
		rst_s1_reg <= reset_pin_n;
		rst_s2_reg <= rst_s1_reg;
		rst_s3_reg <= rst_s2_reg;
	end

	// the filtered level moves only once the second and third stages agree,
	// so a single unsettled sample cannot start or stop the count
	assign rst_low = (rst_s2_reg == rst_s3_reg) ? !rst_s3_reg : rst_low_reg;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rst_low_reg <= 1'b0;
		else
			rst_low_reg <= rst_low;
	end

	// pulses shorter than the minimum are dropped by the counter
	always_ff @(posedge clock)
	begin
		if (!rst_n || !rst_low)
			rst_cnt_reg <= 8'h00;
		else if (rst_cnt_reg != 8'(`RST_MIN_CYCLES))
			rst_cnt_reg <= rst_cnt_reg + 8'h01;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			pin_reset_reg <= 1'b0;
		else
			pin_reset_reg <= rst_low && (rst_cnt_reg == 8'(`RST_MIN_CYCLES));
	end

	assign pin_reset = pin_reset_reg;
	// the raw pin floats the ports combinationally, so no clock is needed
	assign pins_float = !rst_n || !reset_pin_n || pin_reset_reg;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] girq_reg;
	logic [7:0] sleep_reg;
	logic [7:0] periph_reg;
	logic [2:0] unlock_cnt_reg;
	logic wr, rd;
	logic girq_wr;
	logic rd_wait_reg;
	logic [7:0] wbyte;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign girq_wr = wr && paddr == `ADDR_GIRQ;
	assign wbyte = pwdata[7:0];

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// read data is registered, so a read holds one wait state and completes
	// only once prdata carries the addressed register; writes finish at once
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rd_wait_reg <= 1'b0;
		else
			rd_wait_reg <= rd && !rd_wait_reg;
	end

	assign pready = pwrite || rd_wait_reg;

	// ----------------------------------------
	// register decode
	// ----------------------------------------

	always_comb
	begin
		unique case (paddr)
			`ADDR_GIRQ, `ADDR_SLEEP_CTRL, `ADDR_PERIPH_CTRL, `ADDR_STATUS:
				pslverr = 1'b0;
			default:
				pslverr = psel && penable;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			girq_reg <= `GIRQ_RESET;
		else if (girq_wr)
		begin
			girq_reg[`GIRQ_LINE_ONE] <= wbyte[`GIRQ_LINE_ONE];
			girq_reg[`GIRQ_LINE_ZERO] <= wbyte[`GIRQ_LINE_ZERO];
			girq_reg[`GIRQ_LINE_TWO] <= wbyte[`GIRQ_LINE_TWO];
			// select only changes while unlocked and unlock written zero
			if (girq_reg[`GIRQ_UNLOCK] && !wbyte[`GIRQ_UNLOCK])
			begin
				girq_reg[`GIRQ_VSEL] <= wbyte[`GIRQ_VSEL];
				girq_reg[`GIRQ_UNLOCK] <= 1'b0;
			end
			else if (wbyte[`GIRQ_UNLOCK])
				girq_reg[`GIRQ_UNLOCK] <= 1'b1;
		end
		else if (girq_reg[`GIRQ_UNLOCK] && unlock_cnt_reg == `UNLOCK_CYCLES - 3'h1)
			girq_reg[`GIRQ_UNLOCK] <= 1'b0;
	end

	// ----------------------------------------
	// unlock window
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		// writing the unlock bit again restarts its window
		if (!rst_n || !girq_reg[`GIRQ_UNLOCK] || (girq_wr && wbyte[`GIRQ_UNLOCK]))
			unlock_cnt_reg <= 3'h0;
		else
			unlock_cnt_reg <= unlock_cnt_reg + 3'h1;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			sleep_reg <= `SLP_RESET;
		else if (wr && paddr == `ADDR_SLEEP_CTRL)
			sleep_reg <= wbyte & `SLP_RW_MASK;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			periph_reg <= `PER_RESET;
		else if (wr && paddr == `ADDR_PERIPH_CTRL)
			periph_reg <= wbyte & `PER_RW_MASK;
	end

	// ----------------------------------------
	// control outputs
	// ----------------------------------------
	assign vector_base_select = girq_reg[`GIRQ_VSEL];
	assign irq_block = girq_reg[`GIRQ_UNLOCK];
	assign ext_irq_enable = {girq_reg[`GIRQ_LINE_TWO], girq_reg[`GIRQ_LINE_ONE],
		girq_reg[`GIRQ_LINE_ZERO]};
	assign comparator_power = !periph_reg[`PER_CMP_DIS];
	assign jtag_pullup_en = {3{periph_reg[`PER_JTAG_EN]}};

	// ----------------------------------------
	// sleep state machine
	// ----------------------------------------
	state_t state_reg;
	logic [2:0] mode_reg;
	logic [19:0] start_cnt_reg;
	logic wake;
	logic ext_wake;
	logic reset_wake;
	logic sleep_entry;
	logic deep_mode;
	logic [19:0] startup_len;
	logic [2:0] sel_mode;

	assign sel_mode = sleep_reg[`SLP_MODE_MSB:`SLP_MODE_LSB];
	// reserved codes leave the core running
	assign sleep_entry = sleep_instr && sleep_reg[`SLP_SLEEP_EN] &&
		sel_mode <= 3'(sleep_ctrl_pkg::mode_power_save);
	// the oscillator stopping modes need the start-up delay on the way out
	assign deep_mode = mode_reg == 3'(sleep_ctrl_pkg::mode_power_down) ||
		mode_reg == 3'(sleep_ctrl_pkg::mode_power_save);
	assign reset_wake = wake_in.ext_reset || wake_in.watchdog_reset || wake_in.brownout_reset;
	// level lines wake only while the level is held
	assign ext_wake = (wake_in.ext_line_zero_level && girq_reg[`GIRQ_LINE_ZERO]) ||
		(wake_in.ext_line_one_level && girq_reg[`GIRQ_LINE_ONE]) ||
		(wake_in.ext_line_two && girq_reg[`GIRQ_LINE_TWO]);
	// wide enough for the largest fuse setting, so no setting wraps to a short delay
	assign startup_len = `STARTUP_BASE << clock_source_fuses;

	// ----------------------------------------
	// wake decode
	// ----------------------------------------

	always_comb
	begin
		wake = 1'b0;
		unique case (mode_reg)
			sleep_ctrl_pkg::mode_idle:
				wake = ext_wake || reset_wake || wake_in.twi_addr_match ||
					wake_in.timer2_ovf || wake_in.timer2_cmp || wake_in.adc_done ||
					wake_in.storage_ready || wake_in.other_periph ||
					(wake_in.comparator && comparator_power);
			sleep_ctrl_pkg::mode_adc_noise:
				wake = ext_wake || reset_wake || wake_in.twi_addr_match ||
					wake_in.timer2_ovf || wake_in.timer2_cmp || wake_in.adc_done ||
					wake_in.storage_ready;
			sleep_ctrl_pkg::mode_power_down:
				wake = ext_wake || reset_wake || wake_in.twi_addr_match;
			sleep_ctrl_pkg::mode_power_save:
				wake = ext_wake || reset_wake || wake_in.twi_addr_match ||
					(periph_reg[`PER_T2_ASYNC] && global_irq_enable &&
					((wake_in.timer2_ovf && periph_reg[`PER_T2_OVF_IE]) ||
					(wake_in.timer2_cmp && periph_reg[`PER_T2_CMP_IE])));
			default:
				wake = 1'b1;
		endcase
	end

	// ----------------------------------------
	// sleep sequencing
	// ----------------------------------------

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_reg <= st_run;
			mode_reg <= 3'(sleep_ctrl_pkg::mode_idle);
		end
		else
		begin
			unique case (state_reg)
				st_run:
					if (sleep_entry)
					begin
						state_reg <= st_sleep;
						mode_reg <= sel_mode;
					end
				st_sleep:
					if (wake)
					begin
						if (deep_mode)
							state_reg <= st_startup;
						else
							state_reg <= st_run;
					end
				st_startup:
					if (start_cnt_reg == startup_len)
						state_reg <= st_run;
			endcase
		end
	end

	// ----------------------------------------
	// start-up timer
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n || state_reg != st_startup)
			start_cnt_reg <= 20'h00000;
		else
			start_cnt_reg <= start_cnt_reg + 20'h00001;
	end

	// ----------------------------------------
	// conversion trigger
	// ----------------------------------------
	// conversion starts on the entry edge into idle or noise mode
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			adc_start <= 1'b0;
		else
			adc_start <= state_reg == st_run && sleep_entry && periph_reg[`PER_ADC_EN] &&
				sel_mode <= 3'(sleep_ctrl_pkg::mode_adc_noise);
	end

	// ----------------------------------------
	// clock gating
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			clk_en <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1,
				async_timer: 1'b1, oscillator: 1'b1};
		else if (state_reg == st_sleep && !wake)
		begin
			clk_en.cpu <= 1'b0;
			clk_en.flash <= 1'b0;
			clk_en.io <= mode_reg == 3'(sleep_ctrl_pkg::mode_idle);
			clk_en.adc <= mode_reg <= 3'(sleep_ctrl_pkg::mode_adc_noise);
			clk_en.async_timer <= !deep_mode || (periph_reg[`PER_T2_ASYNC] &&
				mode_reg == 3'(sleep_ctrl_pkg::mode_power_save));
			clk_en.oscillator <= !deep_mode;
		end
		else if (state_reg == st_startup)
			clk_en.oscillator <= 1'b1;
		else
			clk_en <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1,
				async_timer: 1'b1, oscillator: 1'b1};
	end

	assign core_running = state_reg == st_run;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (rd)
		begin
			unique case (paddr)
				`ADDR_GIRQ:
					prdata <= {24'h000000, girq_reg & `GIRQ_RW_MASK};
				`ADDR_SLEEP_CTRL:
					prdata <= {24'h000000, sleep_reg};
				`ADDR_PERIPH_CTRL:
					prdata <= {24'h000000, periph_reg};
				`ADDR_STATUS:
					prdata <= {28'h0000000, pin_reset_reg, irq_block, 2'(state_reg)};
				default:
					prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : sleep_ctrl

/* File: sleep_ctrl_asserts.sv */
`timescale 1ns/1ps
module sleep_ctrl_asserts
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic reset_pin_n,
	input wire sleep_ctrl_pkg::clock_enables_t clk_en,
	input wire logic core_running,
	input wire logic adc_start,
	input wire logic irq_block,
	input wire logic pins_float
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence s_all_on;
		clk_en == 6'h3f;
	endsequence
	sequence s_read_girq;
		psel && penable && !pwrite && paddr == 12'h000;
	endsequence
	a_float_on_reset: assert property (!reset_pin_n |-> pins_float)
		else $error("pins driven during reset");
	a_core_gated: assert property ($fell(clk_en.cpu) |-> !core_running)
		else $error("core clock gated while running");
	a_io_needs_osc: assert property (!clk_en.oscillator |-> !clk_en.io && !clk_en.cpu)
		else $error("clock runs without oscillator");
	a_async_only: assert property (clk_en.async_timer && !clk_en.oscillator |->
		!clk_en.adc && !clk_en.flash)
		else $error("clock beside async timer");
	a_resume_clocks: assert property ($rose(core_running) |-> ##[0:2] s_all_on)
		else $error("clocks not restored on wake");
	a_adc_pulse: assert property (adc_start |=> !adc_start)
		else $error("conversion start not a pulse");
	a_unlock_expiry: assert property ($rose(irq_block) |-> ##[1:5] !irq_block)
		else $error("unlock window too long");
	a_unmapped_err: assert property (psel && penable && paddr[11:4] != 8'h00 |-> pslverr)
		else $error("no error on unmapped access");
	a_girq_zeros: assert property (s_read_girq |=> prdata[31:8] == 24'h0 &&
		prdata[4:2] == 3'h0)
		else $error("reserved bits not zero");
endmodule : sleep_ctrl_asserts

bind sleep_ctrl sleep_ctrl_asserts u_chk (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
	.prdata, .pslverr, .reset_pin_n, .clk_en, .core_running, .adc_start, .irq_block,
	.pins_float);

/* File: core_model.sv */
`timescale 1ns/1ps
module core_model
(
	input wire logic clock,
	input wire logic sleep_go,
	input wire logic irq_on,
	input wire sleep_ctrl_pkg::wake_events_t wake_req,
	input wire logic core_running,
	output logic sleep_instr,
	output logic global_irq_enable,
	output sleep_ctrl_pkg::wake_events_t wake_in
);
	always @(posedge clock)
	begin
		// a halted core cannot issue another sleep instruction
		sleep_instr <= sleep_go && core_running;
		global_irq_enable <= irq_on;
		// a wake level stays up until the core runs again
		wake_in <= core_running ? '0 : (wake_in | wake_req);
	end
endmodule : core_model

/* File: tb_top.sv */
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic sleep_go = 1'b0, irq_on = 1'b0, sleep_instr, global_irq_enable;
	logic [3:0] clock_source_fuses = 4'h1;
	logic reset_pin_n = 1'b1, adc_seen = 1'b0;
	sleep_ctrl_pkg::wake_events_t wake_req = '0, wake_in;
	sleep_ctrl_pkg::clock_enables_t clk_en;
	logic core_running, adc_start, comparator_power, vector_base_select, irq_block;
	logic pin_reset, pins_float;
	logic [2:0] ext_irq_enable, jtag_pullup_en;
	logic [5:0] exp_gate [4] = '{6'h0f, 6'h07, 6'h00, 6'h02};
	logic [12:0] wake_bits [4] = '{13'h0001, 13'h0008, 13'h0400, 13'h0020};
	logic [12:0] dud_bits [4] = '{13'h0002, 13'h0001, 13'h0001, 13'h0001};
	int error_cnt = 0, num_checks = 0;

	always #5 clock = ~clock;
	always @(posedge clock) if (adc_start) adc_seen <= 1'b1;

	sleep_ctrl DUT (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sleep_instr, .global_irq_enable, .clock_source_fuses,
		.reset_pin_n, .wake_in, .clk_en, .core_running, .adc_start, .comparator_power,
		.vector_base_select, .irq_block, .ext_irq_enable, .pin_reset, .pins_float,
		.jtag_pullup_en);
	core_model partner (.clock, .sleep_go, .irq_on, .wake_req, .core_running, .sleep_instr,
		.global_irq_enable, .wake_in);

	// --------------------
	// bus and run control
	// --------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		// response and read data are both taken at the completing edge
		e = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge keeps two calls from moving psel twice in one step
		@(posedge clock);
	endtask : apb_xfer
	task automatic print_verdict;
		if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict

	initial
	begin
		logic e;
		tick(4);
		rst_n <= 1'b1;
		tick(1);
		`CHECK("clk_en", 6'h3f, clk_en)
		apb_xfer(1'b0, 12'h000, 8'h00, rd, e);
		`CHECK("girq reset", 32'h0, rd)
		apb_xfer(1'b1, 12'h000, 8'he0, rd, e);
		apb_xfer(1'b1, 12'h000, 8'he1, rd, e);
		`CHECK("irq_block", 1'b1, irq_block)
		apb_xfer(1'b1, 12'h000, 8'he2, rd, e);
		`CHECK("vector select", 1'b1, vector_base_select)
		`CHECK("line enables", 3'h7, ext_irq_enable)
		apb_xfer(1'b0, 12'h000, 8'h00, rd, e);
		`CHECK("girq", 32'he2, rd)
		apb_xfer(1'b1, 12'h000, 8'he1, rd, e);
		tick(8);
		apb_xfer(1'b1, 12'h000, 8'he0, rd, e);
		`CHECK("late select", 1'b1, vector_base_select)
		apb_xfer(1'b0, 12'h010, 8'h00, rd, e);
		`CHECK("unmapped err", 1'b1, e)
		`CHECK("unmapped data", 32'h0, rd)
		// timer 2 runs asynchronously before power-save is used
		apb_xfer(1'b1, 12'h008, 8'h3f, rd, e);
		`CHECK("comparator power", 1'b0, comparator_power)
		irq_on <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			apb_xfer(1'b1, 12'h004, 8'h08 | 8'(m), rd, e);
			sleep_go <= 1'b1;
			tick(1);
			sleep_go <= 1'b0;
			tick(5);
			`CHECK("gated clocks", exp_gate[m], clk_en)
			// each mode first sees an event that must not wake it
			wake_req <= dud_bits[m];
			tick(1);
			wake_req <= '0;
			tick(20);
			`CHECK("still asleep", 1'b0, core_running)
			wake_req <= wake_bits[m];
			tick(1);
			wake_req <= '0;
			tick(10);
			`CHECK("early run", 1'(m < 2), core_running)
			for (int i = 0; i < 200 && core_running !== 1'b1; i++) tick(1);
			tick(2);
			`CHECK("clocks back", 6'h3f, clk_en)
		end
		`CHECK("adc start", 1'b1, adc_seen)
		reset_pin_n <= 1'b0;
		tick(1);
		#1;
		`CHECK("pins float", 1'b1, pins_float)
		tick(200);
		`CHECK("pin reset", 1'b1, pin_reset)
		`CHECK("pullups kept", 3'h7, jtag_pullup_en)
		reset_pin_n <= 1'b1;
		tick(10);
		print_verdict();
	end

	initial
	begin
		tick(20000);
		error_cnt++;
		print_verdict();
	end
endmodule : tb_top
